// [scp_defines.svh]
// constants for the command line parser: character codes, keyword tree, sizes
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// data path sizes
`define SCP_BYTE_W      8
`define SCP_FIFO_DEPTH  16
`define SCP_NODE_W      4
`define SCP_NODE_CNT    13
`define SCP_KW_CHARS    4'hc
`define SCP_KW_BITS     96
`define SCP_PAR_CHARS   3'h7
`define SCP_PAR_BITS    56
`define SCP_TEXT_BITS   32
`define SCP_SFX_MAX     8'h0f
`define SCP_SFX_DEF     4'h1
`define SCP_PCNT_MAX    4'hf

// character codes
`define SCP_CH_LF       8'h0a
`define SCP_CH_WS_MAX   8'h20
`define SCP_CH_STAR     8'h2a
`define SCP_CH_COMMA    8'h2c
`define SCP_CH_ZERO     8'h30
`define SCP_CH_NINE     8'h39
`define SCP_CH_COLON    8'h3a
`define SCP_CH_SEMI     8'h3b
`define SCP_CH_QMARK    8'h3f
`define SCP_CH_UP_A     8'h41
`define SCP_CH_UP_Z     8'h5a
`define SCP_CH_LO_A     8'h61
`define SCP_CH_LO_Z     8'h7a
`define SCP_CH_UPPER    8'hdf
`define SCP_TEN         8'h0a

// node numbers of the keyword tree, zero is the root
`define SCP_ROOT        4'h0
`define SCP_ND_SOURCE   4'h1
`define SCP_ND_FM       4'h2
`define SCP_ND_EXT      4'h3
`define SCP_ND_COUPL    4'h4
`define SCP_ND_FMPOL    4'h5
`define SCP_ND_EXTPOL   4'h6
`define SCP_ND_POWER    4'h7
`define SCP_ND_LEVEL    4'h8
`define SCP_ND_OFFSET   4'h9
`define SCP_ND_ATTEN    4'ha
`define SCP_ND_MODE     4'hb
`define SCP_ND_INT      4'hc
`define SCP_ND_FREQ     4'hd

// tree entries: long name, long length, short length, parent, optional
`define SCP_KW_SOURCE {96'("SOURCE"), 4'h6, 4'h4, `SCP_ROOT, 1'b1}
`define SCP_KW_FM     {96'("FM"), 4'h2, 4'h2, `SCP_ND_SOURCE, 1'b0}
`define SCP_KW_EXT    {96'("EXTERNAL"), 4'h8, 4'h3, `SCP_ND_FM, 1'b0}
`define SCP_KW_COUPL  {96'("COUPLING"), 4'h8, 4'h4, `SCP_ND_EXT, 1'b0}
`define SCP_KW_FMPOL  {96'("POLARITY"), 4'h8, 4'h3, `SCP_ND_FM, 1'b0}
`define SCP_KW_EXTPOL {96'("POLARITY"), 4'h8, 4'h3, `SCP_ND_EXT, 1'b0}
`define SCP_KW_POWER  {96'("POWER"), 4'h5, 4'h3, `SCP_ND_SOURCE, 1'b0}
`define SCP_KW_LEVEL  {96'("LEVEL"), 4'h5, 4'h3, `SCP_ND_POWER, 1'b1}
`define SCP_KW_OFFSET {96'("OFFSET"), 4'h6, 4'h4, `SCP_ND_LEVEL, 1'b0}
`define SCP_KW_ATTEN  {96'("ATTENUATION"), 4'hb, 4'h3, `SCP_ND_POWER, 1'b0}
`define SCP_KW_MODE   {96'("MODE"), 4'h4, 4'h4, `SCP_ND_FM, 1'b0}
`define SCP_KW_INT    {96'("INTERNAL"), 4'h8, 4'h3, `SCP_ND_FM, 1'b0}
`define SCP_KW_FREQ   {96'("FREQUENCY"), 4'h9, 4'h4, `SCP_ND_INT, 1'b0}

// special parameter words
`define SCP_SP_MIN_S  56'("MIN")
`define SCP_SP_MIN_L  56'("MINIMUM")
`define SCP_SP_MAX_S  56'("MAX")
`define SCP_SP_MAX_L  56'("MAXIMUM")
`define SCP_SP_DEF_S  56'("DEF")
`define SCP_SP_DEF_L  56'("DEFAULT")

`endif

// [scp_pkg.sv]
// types shared by the command line parser modules
`include "scp_defines.svh"
package scp_pkg;

	// parse phase of the current command
	typedef enum logic [2:0]
	{
		SCP_HDR = 3'h1,
		SCP_QRY = 3'h2,
		SCP_PAR = 3'h4
	} scp_phase_type;

	// special word found as first parameter
	typedef enum logic [1:0]
	{
		SCP_SP_NONE = 2'h0,
		SCP_SP_MIN  = 2'h1,
		SCP_SP_MAX  = 2'h2,
		SCP_SP_DEF  = 2'h3
	} scp_special_type;

	// one entry of the keyword tree
	typedef struct packed
	{
		logic [`SCP_KW_BITS-1:0] name;
		logic [3:0]              long_len;
		logic [3:0]              short_len;
		logic [`SCP_NODE_W-1:0]  parent;
		logic                    optional;
	} scp_kw_type;

	// whole parser state
	typedef struct packed
	{
		scp_phase_type             phase;
		logic                      at_start;
		logic                      eoi_pend;
		logic [`SCP_NODE_W-1:0]    cur;
		logic [3:0]                inst;
		logic                      query;
		logic                      common;
		logic                      err;
		logic [`SCP_KW_BITS-1:0]   kbuf;
		logic [3:0]                klen;
		logic [3:0]                sfx;
		logic                      sfx_seen;
		logic [`SCP_TEXT_BITS-1:0] text;
		logic [`SCP_PAR_BITS-1:0]  pbuf;
		logic [2:0]                plen;
		logic                      pbad;
		logic                      pany;
		logic                      pnext;
		logic [3:0]                pcount;
		logic                      cmd_valid;
		logic [`SCP_NODE_W-1:0]    cmd_node;
		logic [3:0]                cmd_inst;
		logic                      cmd_query;
		logic                      cmd_common;
		logic [3:0]                cmd_pcount;
		scp_special_type           cmd_special;
		logic [`SCP_TEXT_BITS-1:0] cmd_text;
		logic                      syn_err;
	} scp_parse_type;

endpackage

// [scp_byte_if.sv]
// byte stream carrier between the receive fifo and the parser
`timescale 1ns/1ps
`default_nettype none
interface scp_byte_if
#(
	parameter int WIDTH = 9
);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	// fifo end
	modport store
	(
		input  wr_valid,
		output wr_ready,
		input  wr_data,
		output rd_valid,
		input  rd_ready,
		output rd_data
	);

	// parser end
	modport user
	(
		output wr_valid,
		input  wr_ready,
		output wr_data,
		input  rd_valid,
		output rd_ready,
		input  rd_data
	);
endinterface
`default_nettype wire

// [scp_fifo.sv]
// receive fifo with registered read data and registered flags
`timescale 1ns/1ps
`default_nettype none
module scp_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
)
(
	input  wire logic  clock_in,
	input  wire logic  srst_in,
	scp_byte_if.store  port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
		logic [WIDTH-1:0]            dout;
		logic                        valid;
		logic                        ready;
	} scp_fifo_state_type;

	localparam scp_fifo_state_type RESET = '{ready: 1'b1, default: '0};

	scp_fifo_state_type s;
	scp_fifo_state_type next_s;
	logic               push;
	logic               pull;

	// depth must be a power of two so the pointers wrap by themselves
	always_comb
	begin
		next_s = s;
		push = port.wr_valid && s.ready;
		pull = port.rd_ready && s.valid;
		if (push)
		begin
			next_s.mem[s.wptr] = port.wr_data;
			next_s.wptr = AW'(s.wptr + 1'b1);
		end
		if (pull)
			next_s.rptr = AW'(s.rptr + 1'b1);
		next_s.count = (AW+1)'(s.count + (AW+1)'(push) - (AW+1)'(pull));
		// flags and data are looked ahead so every output is a flop
		next_s.dout = next_s.mem[next_s.rptr];
		next_s.valid = next_s.count != '0;
		next_s.ready = next_s.count != (AW+1)'(DEPTH);
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			s <= RESET;
		else
			s <= next_s;
	end

	assign port.wr_ready = s.ready;
	assign port.rd_valid = s.valid;
	assign port.rd_data  = s.dout;
endmodule
`default_nettype wire

// [scp_parser.sv]
// command line parser: splits lines into commands and resolves keyword paths
//
// Contract
// - a lower level header gives the whole keyword path from the root, colon separated.
// - a keyword is resolved by its level, so one word at two levels gives two nodes.
// - headers with and without optional keywords resolve to the same node, unless the optional keyword ends the header.
// - only the full long form or the exact short form of a keyword is accepted.
// - keyword letters are compared without regard to case.
// - parameters follow the header after white space and are split by commas.
// - the words for minimum, maximum and default are recognised as the first parameter of a query.
// - a numeric suffix picks the instance, which later keywords without a suffix keep; no suffix at all means instance one.
// - a line ends on newline, newline with end flag, or end flag with the last byte.
// - commands split at semicolons and a colon right after one restarts at the root.
// - without that colon the next header starts below the parent of the last keyword of the previous one; after a command with an error it starts at the root.
// - every new line starts resolving from the root.
// - a question mark right after the header marks a query.
// - codes up to 32 decimal count as white space between header and parameters.
// - a header starting with an asterisk is a common command outside the tree.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_parser
#(
	parameter int FIFO_DEPTH = `SCP_FIFO_DEPTH
)
(
	input  wire logic                      clock_in,
	input  wire logic                      srst_in,
	input  wire logic [`SCP_BYTE_W-1:0]    rx_data_in,
	input  wire logic                      rx_eoi_in,
	input  wire logic                      rx_valid_in,
	output logic                           rx_ready_out,
	input  wire logic                      cmd_ready_in,
	output logic                           cmd_valid_out,
	output logic [`SCP_NODE_W-1:0]         cmd_node_out,
	output logic [3:0]                     cmd_inst_out,
	output logic                           cmd_query_out,
	output logic                           cmd_common_out,
	output logic [3:0]                     cmd_param_count_out,
	output logic [1:0]                     cmd_special_out,
	output logic [`SCP_TEXT_BITS-1:0]      cmd_text_out,
	output logic                           syntax_err_out
);
	localparam scp_pkg::scp_parse_type RESET = '{
		phase:    scp_pkg::SCP_HDR,
		at_start: 1'b1,
		cur:      `SCP_ROOT,
		inst:     `SCP_SFX_DEF,
		cmd_special: scp_pkg::SCP_SP_NONE,
		default:  '0
	};

	// keyword tree lookup, entry zero stands for the root
	function automatic scp_pkg::scp_kw_type kw_entry(input logic [`SCP_NODE_W-1:0] idx);
		scp_pkg::scp_kw_type k;
		k = '0;
		case (idx)
			`SCP_ND_SOURCE: k = `SCP_KW_SOURCE;
			`SCP_ND_FM:     k = `SCP_KW_FM;
			`SCP_ND_EXT:    k = `SCP_KW_EXT;
			`SCP_ND_COUPL:  k = `SCP_KW_COUPL;
			`SCP_ND_FMPOL:  k = `SCP_KW_FMPOL;
			`SCP_ND_EXTPOL: k = `SCP_KW_EXTPOL;
			`SCP_ND_POWER:  k = `SCP_KW_POWER;
			`SCP_ND_LEVEL:  k = `SCP_KW_LEVEL;
			`SCP_ND_OFFSET: k = `SCP_KW_OFFSET;
			`SCP_ND_ATTEN:  k = `SCP_KW_ATTEN;
			`SCP_ND_MODE:   k = `SCP_KW_MODE;
			`SCP_ND_INT:    k = `SCP_KW_INT;
			`SCP_ND_FREQ:   k = `SCP_KW_FREQ;
			default:        k = '0;
		endcase
		return k;
	endfunction

	scp_byte_if #(.WIDTH(`SCP_BYTE_W + 1)) bus ();

	scp_pkg::scp_parse_type   s;
	scp_pkg::scp_parse_type   next_s;
	logic [`SCP_NODE_CNT:1]   hit;
	logic [`SCP_NODE_W-1:0]   hit_node;
	logic [`SCP_BYTE_W-1:0]   ch;
	logic                     eoi;
	logic                     stall;
	logic                     pop;
	logic                     ws;
	logic                     letter;
	logic                     digit;
	logic                     do_close;
	logic                     do_end;
	logic                     line_end;
	logic                     cerr;
	logic [`SCP_NODE_W-1:0]   leaf;
	logic [3:0]               leaf_inst;
	scp_pkg::scp_kw_type      leaf_ent;
	logic [7:0]               sfx_val;
	scp_pkg::scp_special_type spc;

	// bytes are buffered so a slow command consumer backs up the link
	assign bus.wr_valid = rx_valid_in;
	assign bus.wr_data  = {rx_eoi_in, rx_data_in};
	assign bus.rd_ready = pop;
	assign rx_ready_out = bus.wr_ready;

	scp_fifo #(
		.WIDTH (`SCP_BYTE_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.port     (bus)
	);

	// one matcher per tree entry against the collected keyword
	for (genvar e = 1; e <= `SCP_NODE_CNT; e++)
	begin : g_kw
		localparam scp_pkg::scp_kw_type ENT = kw_entry(`SCP_NODE_W'(e));
		localparam scp_pkg::scp_kw_type UP  = kw_entry(ENT.parent);
		localparam int SH = 8 * (ENT.long_len - ENT.short_len);
		logic name_ok;
		logic place_ok;
		// buffer is right aligned and zero padded, so plain compares suffice
		assign name_ok = (s.kbuf == ENT.name) ||
			(s.klen == ENT.short_len && s.kbuf == (ENT.name >> SH));
		// a child of the current node, or one reached past an omitted optional
		assign place_ok = (ENT.parent == s.cur) ||
			(UP.optional && UP.parent == s.cur);
		assign hit[e] = name_ok && place_ok;
	end

	// lowest numbered hit wins; a direct child and a skip cannot both match
	always_comb
	begin
		hit_node = `SCP_ROOT;
		for (int i = `SCP_NODE_CNT; i >= 1; i--)
		begin
			if (hit[i])
				hit_node = `SCP_NODE_W'(i);
		end
	end

	// first parameter against the special words
	always_comb
	begin
		spc = scp_pkg::SCP_SP_NONE;
		if (!s.pbad && s.query)
		begin
			if (s.pbuf == `SCP_SP_MIN_S || s.pbuf == `SCP_SP_MIN_L)
				spc = scp_pkg::SCP_SP_MIN;
			else if (s.pbuf == `SCP_SP_MAX_S || s.pbuf == `SCP_SP_MAX_L)
				spc = scp_pkg::SCP_SP_MAX;
			else if (s.pbuf == `SCP_SP_DEF_S || s.pbuf == `SCP_SP_DEF_L)
				spc = scp_pkg::SCP_SP_DEF;
			else
				spc = scp_pkg::SCP_SP_NONE;
		end
	end

	// character classes, letters folded to upper case
	always_comb
	begin
		eoi = bus.rd_data[`SCP_BYTE_W];
		ch = bus.rd_data[`SCP_BYTE_W-1:0];
		if (ch >= `SCP_CH_LO_A && ch <= `SCP_CH_LO_Z)
			ch = ch & `SCP_CH_UPPER;
		ws = ch <= `SCP_CH_WS_MAX;
		letter = ch >= `SCP_CH_UP_A && ch <= `SCP_CH_UP_Z;
		digit = ch >= `SCP_CH_ZERO && ch <= `SCP_CH_NINE;
		sfx_val = 8'(({4'h0, s.sfx} * `SCP_TEN) + (ch - `SCP_CH_ZERO));
	end

	// main parse step, at most one byte per cycle
	always_comb
	begin
		next_s = s;
		next_s.syn_err = 1'b0;
		do_close = 1'b0;
		do_end = 1'b0;
		line_end = 1'b0;
		cerr = 1'b0;
		leaf = s.cur;
		leaf_inst = s.inst;
		if (s.cmd_valid && cmd_ready_in)
			next_s.cmd_valid = 1'b0;
		// a command waiting for the consumer holds the whole parser
		stall = s.cmd_valid && !cmd_ready_in;
		pop = !stall && !s.eoi_pend && bus.rd_valid;
		// end flag on a content byte closes the line one cycle later
		if (!stall && s.eoi_pend)
		begin
			next_s.eoi_pend = 1'b0;
			do_end = 1'b1;
			line_end = 1'b1;
		end
		if (pop)
		begin
			if (ch == `SCP_CH_LF)
			begin
				do_end = 1'b1;
				line_end = 1'b1;
			end
			else if (ch == `SCP_CH_SEMI)
			begin
				do_end = 1'b1;
				next_s.eoi_pend = eoi;
			end
			else
			begin
				next_s.eoi_pend = eoi;
				case (s.phase)
					scp_pkg::SCP_HDR:
					begin
						if (ws)
						begin
							if (!s.at_start)
							begin
								do_close = 1'b1;
								next_s.phase = scp_pkg::SCP_PAR;
							end
						end
						else if (ch == `SCP_CH_COLON)
						begin
							next_s.at_start = 1'b0;
							if (s.at_start)
								next_s.cur = `SCP_ROOT;
							else
								do_close = 1'b1;
						end
						else if (ch == `SCP_CH_QMARK)
						begin
							next_s.at_start = 1'b0;
							do_close = 1'b1;
							next_s.query = 1'b1;
							next_s.phase = scp_pkg::SCP_QRY;
						end
						else if (ch == `SCP_CH_STAR && s.at_start)
						begin
							next_s.at_start = 1'b0;
							next_s.common = 1'b1;
						end
						else if (letter)
						begin
							next_s.at_start = 1'b0;
							if (s.sfx_seen || s.klen == `SCP_KW_CHARS)
								next_s.err = 1'b1;
							else
							begin
								next_s.kbuf = {s.kbuf[`SCP_KW_BITS-9:0], ch};
								next_s.klen = s.klen + 4'h1;
							end
						end
						else if (digit)
						begin
							next_s.at_start = 1'b0;
							if (s.klen == 4'h0 || sfx_val > `SCP_SFX_MAX)
								next_s.err = 1'b1;
							next_s.sfx = sfx_val[3:0];
							next_s.sfx_seen = 1'b1;
						end
						else
						begin
							next_s.at_start = 1'b0;
							next_s.err = 1'b1;
						end
					end
					scp_pkg::SCP_QRY:
					begin
						// only white space may follow the question mark
						if (ws)
							next_s.phase = scp_pkg::SCP_PAR;
						else
							next_s.err = 1'b1;
					end
					scp_pkg::SCP_PAR:
					begin
						if (ch == `SCP_CH_COMMA)
						begin
							next_s.pnext = 1'b1;
							if (s.pcount != `SCP_PCNT_MAX)
								next_s.pcount = s.pcount + 4'h1;
						end
						else if (!ws)
						begin
							next_s.pany = 1'b1;
							// only the first parameter is kept, and only as a word
							if (!s.pnext)
							begin
								if (letter && s.plen != `SCP_PAR_CHARS)
								begin
									next_s.pbuf = {s.pbuf[`SCP_PAR_BITS-9:0], ch};
									next_s.plen = s.plen + 3'h1;
								end
								else
									next_s.pbad = 1'b1;
							end
						end
					end
					default:
						next_s.phase = scp_pkg::SCP_HDR;
				endcase
			end
		end

		// close the keyword under construction
		if (do_close || (do_end && s.phase == scp_pkg::SCP_HDR && !s.at_start))
		begin
			if (s.klen == 4'h0)
				cerr = 1'b1;
			else if (!s.common)
			begin
				if (hit_node == `SCP_ROOT)
					cerr = 1'b1;
				else
				begin
					leaf = hit_node;
					if (s.sfx_seen)
						leaf_inst = s.sfx;
				end
			end
			if (cerr)
				next_s.err = 1'b1;
			next_s.cur = leaf;
			next_s.inst = leaf_inst;
			next_s.text = s.kbuf[`SCP_TEXT_BITS-1:0];
			next_s.kbuf = '0;
			next_s.klen = 4'h0;
			next_s.sfx = 4'h0;
			next_s.sfx_seen = 1'b0;
		end

		// entry of the resolved keyword, whose parent a relative header continues from
		leaf_ent = kw_entry(leaf);
		// end of a command: hand it on or drop it
		if (do_end)
		begin
			if (!s.at_start)
			begin
				if (s.err || cerr)
					next_s.syn_err = 1'b1;
				else
				begin
					next_s.cmd_valid = 1'b1;
					next_s.cmd_node = s.common ? `SCP_ROOT : leaf;
					next_s.cmd_inst = leaf_inst;
					next_s.cmd_query = s.query;
					next_s.cmd_common = s.common;
					next_s.cmd_pcount = s.pcount + {3'h0, s.pany};
					next_s.cmd_special = spc;
					next_s.cmd_text = (s.phase == scp_pkg::SCP_HDR) ?
						s.kbuf[`SCP_TEXT_BITS-1:0] : s.text;
				end
			end
			next_s.phase = scp_pkg::SCP_HDR;
			next_s.at_start = 1'b1;
			next_s.query = 1'b0;
			next_s.common = 1'b0;
			next_s.err = 1'b0;
			next_s.kbuf = '0;
			next_s.klen = 4'h0;
			next_s.sfx = 4'h0;
			next_s.sfx_seen = 1'b0;
			next_s.pbuf = '0;
			next_s.plen = 3'h0;
			next_s.pbad = 1'b0;
			next_s.pany = 1'b0;
			next_s.pnext = 1'b0;
			next_s.pcount = 4'h0;
			next_s.inst = `SCP_SFX_DEF;
			// context for the next header; an error forgets the path
			if (line_end || s.err || cerr)
				next_s.cur = `SCP_ROOT;
			else if (s.at_start || s.common)
				next_s.cur = s.cur;
			else
				next_s.cur = leaf_ent.parent;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			s <= RESET;
		else
			s <= next_s;
	end

	// outputs straight from the state flops
	assign cmd_valid_out       = s.cmd_valid;
	assign cmd_node_out        = s.cmd_node;
	assign cmd_inst_out        = s.cmd_inst;
	assign cmd_query_out       = s.cmd_query;
	assign cmd_common_out      = s.cmd_common;
	assign cmd_param_count_out = s.cmd_pcount;
	assign cmd_special_out     = s.cmd_special;
	assign cmd_text_out        = s.cmd_text;
	assign syntax_err_out      = s.syn_err;
endmodule
`default_nettype wire

// [scp_parser_sva.sv]
// concurrent checks on the command line parser ports
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_parser_sva
(
	input wire logic                      clock_in,
	input wire logic                      srst_in,
	input wire logic                      rx_ready_out,
	input wire logic                      cmd_ready_in,
	input wire logic                      cmd_valid_out,
	input wire logic [`SCP_NODE_W-1:0]    cmd_node_out,
	input wire logic [3:0]                cmd_inst_out,
	input wire logic                      cmd_query_out,
	input wire logic                      cmd_common_out,
	input wire logic [3:0]                cmd_param_count_out,
	input wire logic [1:0]                cmd_special_out,
	input wire logic [`SCP_TEXT_BITS-1:0] cmd_text_out,
	input wire logic                      syntax_err_out
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (srst_in);

	// a waiting command must not change, or the consumer would read a mix of two
	a_cmd_holds: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out
		&& $stable({cmd_node_out, cmd_inst_out, cmd_param_count_out, cmd_text_out}))
		else $error("command changed while waiting");
	a_take_clears: assert property (cmd_valid_out && cmd_ready_in |=> !cmd_valid_out)
		else $error("command still valid after take");
	a_err_pulse: assert property (syntax_err_out |=> !syntax_err_out)
		else $error("syntax error longer than one cycle");
	a_err_no_cmd: assert property (syntax_err_out |-> !$rose(cmd_valid_out))
		else $error("dropped command was emitted");
	a_common_root: assert property (cmd_valid_out && cmd_common_out |-> cmd_node_out == 4'h0)
		else $error("common command carries a tree node");
	a_tree_node: assert property (cmd_valid_out && !cmd_common_out |-> cmd_node_out != 4'h0)
		else $error("device command without a tree node");
	a_special_query: assert property (cmd_valid_out && cmd_special_out != 2'h0
		|-> cmd_query_out && cmd_param_count_out != 4'h0)
		else $error("special word outside a query parameter");
	a_reset_idle: assert property ($past(srst_in) |-> rx_ready_out && !cmd_valid_out
		&& !syntax_err_out)
		else $error("outputs not idle after reset");

	// main scenarios seen
	c_query: cover property (cmd_valid_out && cmd_query_out);
	c_common: cover property (cmd_valid_out && cmd_common_out);
	c_special: cover property (cmd_valid_out && cmd_special_out != 2'h0);
	c_error: cover property (syntax_err_out);
endmodule
bind scp_parser scp_parser_sva scp_parser_sva_i (.clock_in, .srst_in, .rx_ready_out,
	.cmd_ready_in, .cmd_valid_out, .cmd_node_out, .cmd_inst_out, .cmd_query_out,
	.cmd_common_out, .cmd_param_count_out, .cmd_special_out, .cmd_text_out, .syntax_err_out);
`default_nettype wire

// [scp_remote_model.sv]
// remote controller model: sends queued line bytes over valid and ready
`timescale 1ns/1ps
`default_nettype none
module scp_remote_model
(
	input  wire logic       clock_in,
	input  wire logic       ready_in,
	input  wire logic       slow_in,
	output logic [7:0]      data_out,
	output logic            eoi_out,
	output logic            valid_out
);
	logic [8:0] pend[$];
	logic       took;

	// a line ends in a newline or flags its last byte as the end
	task automatic send(input string s, input bit eoi_end);
		for (int i = 0; i < s.len(); i++)
			pend.push_back({eoi_end && i == s.len() - 1, s[i]});
	endtask

	initial
	begin
		valid_out = 1'b0;
		{eoi_out, data_out} = 9'h000;
		took = 1'b0;
	end

	// a byte is taken when valid and ready meet at the rising edge
	always @(posedge clock_in)
		took = valid_out && ready_in;

	// held until taken; idle data flips so a stale byte never looks fresh
	always @(negedge clock_in)
		if (took || !valid_out)
		begin
			took = 1'b0;
			if (pend.size() != 0 && !(slow_in && $urandom_range(0, 2) == 0))
			begin
				{eoi_out, data_out} = pend.pop_front();
				valid_out = 1'b1;
			end
			else
			begin
				valid_out = 1'b0;
				{eoi_out, data_out} = ~{eoi_out, data_out};
			end
		end
endmodule
`default_nettype wire

// [test_scpi_command_line_parser.sv]
// self-checking bench for the command line parser
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module test_scpi_command_line_parser;
	typedef struct packed {logic e; logic [3:0] nd, in; logic [1:0] qc; logic [3:0] pc;
		logic [1:0] sp; logic [31:0] tx;} scp_exp_type;
	logic clock_in, srst_in, cmd_ready_in, slow, rx_ready_out, cmd_valid_out;
	logic cmd_query_out, cmd_common_out, syntax_err_out, rx_eoi_in, rx_valid_in;
	logic [7:0]  rx_data_in;
	logic [3:0]  cmd_node_out, cmd_inst_out, cmd_param_count_out;
	logic [1:0]  cmd_special_out;
	logic [31:0] cmd_text_out;
	int          errors, checks_done, cycles;
	scp_exp_type exp_q[$];

	scp_parser scp_parser_i (.clock_in, .srst_in, .rx_data_in, .rx_eoi_in, .rx_valid_in,
		.rx_ready_out, .cmd_ready_in, .cmd_valid_out, .cmd_node_out, .cmd_inst_out,
		.cmd_query_out, .cmd_common_out, .cmd_param_count_out, .cmd_special_out,
		.cmd_text_out, .syntax_err_out);
	scp_remote_model scp_remote_model_i (.clock_in, .ready_in(rx_ready_out), .slow_in(slow),
		.data_out(rx_data_in), .eoi_out(rx_eoi_in), .valid_out(rx_valid_in));

	task automatic conclude;
		$display("Counts: checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic fail(input string m);
		errors++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic exp_cmd(input logic [3:0] nd, in, input logic [1:0] qc,
		input logic [3:0] pc, input logic [1:0] sp, input logic [31:0] tx = 32'h0);
		exp_q.push_back({1'b0, nd, in, qc, pc, sp, tx});
	endtask
	task automatic exp_err;
		exp_q.push_back({1'b1, 48'h0});
	endtask
	task automatic line(input string s, input bit eoi_end = 1'b0);
		scp_remote_model_i.send(s, eoi_end);
	endtask
	// text is only compared where a note gives one
	task automatic cmp_cmd(input scp_exp_type x);
		checks_done++;
		if (x.e !== 1'b0 || {cmd_node_out, cmd_inst_out, cmd_query_out, cmd_common_out,
			cmd_param_count_out, cmd_special_out} !== {x.nd, x.in, x.qc, x.pc, x.sp}
			|| (x.tx != 32'h0 && cmd_text_out !== x.tx))
			fail($sformatf("command node %h inst %h, note node %h inst %h",
				cmd_node_out, cmd_inst_out, x.nd, x.in));
	endtask
	task automatic cmp_err(input scp_exp_type x);
		checks_done++;
		if (x.e !== 1'b1)
			fail($sformatf("syntax error, note node %h", x.nd));
	endtask
	task automatic drain;
		for (int i = 0; i < 3000 && (scp_remote_model_i.pend.size() != 0 || exp_q.size() != 0); i++)
			@(negedge clock_in);
		if (exp_q.size() != 0)
			fail("results missing");
	endtask

	always #10 clock_in = ~clock_in;

	// the consumer stalls at random in slow runs, which backs up the fifo
	always @(negedge clock_in)
		cmd_ready_in <= !slow || $urandom_range(0, 3) == 0;

	// each result takes the oldest note
	always @(posedge clock_in)
		if (!srst_in && (syntax_err_out === 1'b1 || (cmd_valid_out && cmd_ready_in) === 1'b1))
		begin
			if (exp_q.size() == 0)
				fail("result without a note");
			else if (syntax_err_out === 1'b1)
				cmp_err(exp_q.pop_front());
			else
				cmp_cmd(exp_q.pop_front());
		end

	// hang guard
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail("timeout");
			conclude();
		end
	end

	initial
	begin
		int n;
		clock_in = 1'b0;
		srst_in = 1'b1;
		slow = 1'b0;
		n = $urandom(94082);
		repeat (16) @(negedge clock_in);
		srst_in = 1'b0;
		exp_cmd(4'h2, 4'h1, 2'b10, 4'h0, 2'h0, 32'("FM"));
		line("fm?\n");
		exp_cmd(4'h4, 4'h2, 2'b00, 4'h1, 2'h0, 32'("LING"));
		line("SOURce:FM:EXTernal2:COUPling AC\n");
		exp_cmd(4'h5, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_cmd(4'h6, 4'h1, 2'b00, 4'h1, 2'h0);
		line("sour:fm:pol NORM;EXT:POL NORM\n");
		exp_cmd(4'hb, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_cmd(4'hd, 4'h1, 2'b00, 4'h1, 2'h0);
		line("SOUR:FM:MODE LOCK;INT:FREQ 1\n");
		exp_cmd(4'ha, 4'h1, 2'b10, 4'h1, 2'h1);
		line("POW:ATT? MIN\n");
		exp_cmd(4'ha, 4'h1, 2'b10, 4'h1, 2'h2);
		line("POW:ATT? MAXIMUM\n");
		exp_cmd(4'ha, 4'h1, 2'b10, 4'h1, 2'h3);
		line("POW:ATT? DEF\n");
		exp_cmd(4'h9, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_cmd(4'h9, 4'h1, 2'b00, 4'h1, 2'h0);
		line("POW:OFFS 1\nSOURCE:POWER:LEVEL:OFFSET 1\n");
		exp_cmd(4'h5, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_cmd(4'ha, 4'h1, 2'b00, 4'h3, 2'h0);
		line("FM:POL 1;:POW:ATT 5,6,7\n");
		exp_err();
		line("FM:POLA 1\n");
		exp_cmd(4'hb, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_err();
		line("FM:MODE 1\nPOL 1\n");
		exp_cmd(4'h0, 4'h1, 2'b01, 4'h0, 2'h0, 32'("RST"));
		exp_cmd(4'h0, 4'h1, 2'b11, 4'h0, 2'h0, 32'("ESR"));
		line("*RST\n*ESR?\n");
		exp_cmd(4'h2, 4'h1, 2'b10, 4'h0, 2'h0);
		line("FM?", 1'b1);
		exp_cmd(4'hb, 4'h1, 2'b00, 4'h2, 2'h0);
		line("FM:MODE\tX,Y\n", 1'b1);
		exp_cmd(4'h2, 4'h1, 2'b10, 4'h0, 2'h0);
		exp_cmd(4'h7, 4'h1, 2'b10, 4'h0, 2'h0);
		line("FM?;;POW?\n");
		// a common command inside a path reports no node and keeps the path
		exp_cmd(4'h5, 4'h1, 2'b00, 4'h1, 2'h0);
		exp_cmd(4'h0, 4'h1, 2'b01, 4'h0, 2'h0, 32'("RST"));
		exp_cmd(4'hb, 4'h1, 2'b00, 4'h1, 2'h0);
		line("FM:POL 1;*RST;MODE 1\n");
		drain();
		slow = 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			n = $urandom_range(1, 15);
			exp_cmd(4'h4, n[3:0], 2'b00, 4'h1, 2'h0);
			line($sformatf("SOUR:FM:EXT%0d:COUP AC\n", n));
		end
		drain();
		conclude();
	end
endmodule
`default_nettype wire
